// file: pkg/dspa_consts.vh
// constants of the two-segment bus arbiter: register map, fields,
// reset values and state codes; included by the arbiter top level only
`ifndef DSPA_CONSTS_VH
`define DSPA_CONSTS_VH

// register byte offsets on the AHB-Lite slave
`define DSPA_OFS_CTRL_A 8'h00
`define DSPA_OFS_CTRL_B 8'h04
`define DSPA_OFS_STATUS 8'h08

// control register fields (16 bits wide)
`define DSPA_CTRL_W 16
`define DSPA_GRP_LSB 0
`define DSPA_GRP_W 7
`define DSPA_PARK_BIT 8
`define DSPA_CTRL_RST 16'h0000

// master indices; the bridge's own master sits at index 6
`define DSPA_NMST 7
`define DSPA_NEXT 6
`define DSPA_BRIDGE 3'h6
`define DSPA_LOW_SLOT 3'h7
`define DSPA_GNT_RST 7'h40

// grant state machine codes
`define DSPA_ST_PARK 2'h0
`define DSPA_ST_OWN 2'h1
`define DSPA_ST_DEAD 2'h2

// values the bridge drives onto an idle parked bus
`define DSPA_PARK_AD 32'h00000000
`define DSPA_PARK_CBE 4'h0
`define DSPA_PARK_PAR 1'b0

`endif

// file: hdl/dspa_sync2.v
// two-flop synchroniser for pin inputs of the bus segments
// assumes: one core clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module dspa_sync2 #(
  parameter W = 16,
  parameter [15:0] RST_VAL = 16'hffff
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // pins in, synchronised level out
  input wire [W-1:0] pinIn,
  output reg [W-1:0] syncOut
);

  reg [W-1:0] metaQ;

  ////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      metaQ <= RST_VAL[W-1:0];
      syncOut <= RST_VAL[W-1:0];
    end else begin
      metaQ <= pinIn;
      syncOut <= metaQ;
    end
  end

endmodule // dspa_sync2

`default_nettype wire

// file: hdl/dspa_rr_pick.v
// round-robin picker over eight request slots
// assumes: lastIdx is the slot served most recently; purely combinational
`timescale 1ns/1ps
`default_nettype none

module dspa_rr_pick (
  // requests and rotation pointer
  input wire [7:0] req,
  input wire [2:0] lastIdx,
  // result
  output reg anyReq,
  output reg [2:0] winIdx
);

  ////////////////////////////////////////////////////////////////////////
  // scan from the slot after lastIdx; nearest requester wins
  always @* begin : pick
    integer k;
    reg [2:0] cand;
    cand = lastIdx;
    anyReq = 1'b0;
    winIdx = lastIdx;
    for (k = 8; k >= 1; k = k - 1) begin
      cand = lastIdx + k[2:0];
      if (req[cand]) begin
        anyReq = 1'b1;
        winIdx = cand;
      end
    end
  end

endmodule // dspa_rr_pick

`default_nettype wire

// file: hdl/dspa_arbiter.v
// two independent bus-segment arbiters with an AHB-Lite register slave
// assumes: segment pins are asynchronous to core_clk and pass two flops;
// internal requests come from bridge logic on core_clk
//
// Contract
// - one independent arbiter per segment, seven masters
// - six external requests plus internal; matching grants
// - every request in exactly one priority group
// - each master's group individually programmable
// - works with all masters in one group
// - round-robin rotation inside each group
// - low group is one slot in high rotation
// - 16-bit control register steers groups and parking
// - idle bus parks on last owner or bridge
// - reset parks on bridge, drives idle bus lines; drive is off during reset, on from the first edge after
`timescale 1ns/1ps
`default_nettype none
`include "dspa_consts.vh"

module dspa_arbiter (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // segment A pins (active low)
  input wire [5:0] segAReq_b,
  output wire [5:0] segAGnt_b,
  input wire segAFrame_b,
  input wire segAIrdy_b,
  // segment A internal master
  input wire segAIntReq,
  output wire segAIntGnt,
  // segment A park drive of address/data, command and parity
  output wire segAParkOe,
  output wire [31:0] segAParkAd,
  output wire [3:0] segAParkCbe,
  output wire segAParkPar,
  // segment B pins (active low)
  input wire [5:0] segBReq_b,
  output wire [5:0] segBGnt_b,
  input wire segBFrame_b,
  input wire segBIrdy_b,
  // segment B internal master
  input wire segBIntReq,
  output wire segBIntGnt,
  // segment B park drive
  output wire segBParkOe,
  output wire [31:0] segBParkAd,
  output wire [3:0] segBParkCbe,
  output wire segBParkPar
);

  reg [15:0] ctrlAQ;
  reg [15:0] ctrlBQ;
  reg wrPendQ;
  reg [7:0] wrAddrQ;
  wire [15:0] pinRaw;
  wire [15:0] pinSync;
  wire [13:0] segGnt;
  wire [1:0] segParkOe;
  wire [15:0] segStat;
  wire [31:0] statWord;
  wire addrValid;
  reg [31:0] rdData;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; idle high lines reset to the released level
  // per segment byte: [5:0] requests, [6] frame, [7] irdy; b above a
  assign pinRaw = {segBIrdy_b, segBFrame_b, segBReq_b,
                   segAIrdy_b, segAFrame_b, segAReq_b};

  dspa_sync2 #(
    .W(16),
    .RST_VAL(16'hffff)
  ) uSync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(pinRaw),
    .syncOut(pinSync)
  );

  ////////////////////////////////////////////////////////////////////////
  // one arbiter per segment, sharing nothing but the clock and reset
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : gSeg
      wire [15:0] ctl;
      wire [6:0] req;
      wire [6:0] lowSel;
      wire [6:0] hiReq;
      wire [6:0] loReq;
      wire hiAny;
      wire [2:0] hiWin;
      wire loAny;
      wire [2:0] loWin;
      wire [2:0] winIdx;
      wire busIdle;
      wire parkLast;
      wire ownReq;
      reg [1:0] stateQ;
      reg [2:0] ownerQ;
      reg [2:0] nextOwnerQ;
      reg [6:0] gntQ;
      reg [2:0] hiLastQ;
      reg [2:0] loLastQ;
      reg startedQ;
      reg parkOeQ;

      assign ctl = (s == 0) ? ctrlAQ : ctrlBQ;
      // six external pins (active low) plus the internal master
      assign req = {(s == 0) ? segAIntReq : segBIntReq,
                    ~pinSync[8*s +: 6]};
      assign busIdle = pinSync[8*s + 6] & pinSync[8*s + 7]; // frame and irdy high
      assign parkLast = ctl[`DSPA_PARK_BIT];

      // a set bit places that master in the low group, clear in high
      assign lowSel = ctl[`DSPA_GRP_LSB +: `DSPA_GRP_W];
      assign hiReq = req & ~lowSel;
      assign loReq = req & lowSel;

      // high ring: seven masters plus the low group as slot 7
      dspa_rr_pick uHi (
        .req({|loReq, hiReq}),
        .lastIdx(hiLastQ),
        .anyReq(hiAny),
        .winIdx(hiWin)
      );

      // low ring: only low-group members take part
      dspa_rr_pick uLo (
        .req({1'b0, loReq}),
        .lastIdx(loLastQ),
        .anyReq(loAny),
        .winIdx(loWin)
      );

      // an empty group never wins, so one group alone works too
      assign winIdx = (hiWin == `DSPA_LOW_SLOT) ? loWin : hiWin;
      assign ownReq = req[ownerQ];

      ////////////////////////////////////////////////////////////////////
      // grant machine; owner changes pass a dead cycle with no grant
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          stateQ <= `DSPA_ST_PARK;
          ownerQ <= `DSPA_BRIDGE;
          nextOwnerQ <= `DSPA_BRIDGE;
          gntQ <= `DSPA_GNT_RST;
          hiLastQ <= `DSPA_LOW_SLOT;
          loLastQ <= `DSPA_BRIDGE;
          startedQ <= 1'b0;
        end else begin
          case (stateQ)
            `DSPA_ST_PARK: begin
              startedQ <= 1'b0;
              if (hiAny) begin
                hiLastQ <= hiWin;
                if (hiWin == `DSPA_LOW_SLOT) begin
                  loLastQ <= loWin;
                end
                if (gntQ[winIdx]) begin
                  // parked master asks: keep its grant
                  stateQ <= `DSPA_ST_OWN;
                end else begin
                  gntQ <= 7'h00;
                  nextOwnerQ <= winIdx;
                  stateQ <= `DSPA_ST_DEAD;
                end
              end else if (!parkLast && ownerQ != `DSPA_BRIDGE) begin
                // parking moved to the bridge by software
                gntQ <= 7'h00;
                nextOwnerQ <= `DSPA_BRIDGE;
                stateQ <= `DSPA_ST_DEAD;
              end
            end
            `DSPA_ST_DEAD: begin
              // single grant only, from one owner index
              ownerQ <= nextOwnerQ;
              gntQ <= 7'h01 << nextOwnerQ;
              startedQ <= 1'b0;
              stateQ <= req[nextOwnerQ] ? `DSPA_ST_OWN : `DSPA_ST_PARK;
            end
            `DSPA_ST_OWN: begin
              if (!busIdle) begin
                startedQ <= 1'b1;
              end
              // re-arbitrate when owner lets go or its transfer ended
              if (!ownReq || (startedQ && busIdle)) begin
                startedQ <= 1'b0;
                if (hiAny) begin
                  hiLastQ <= hiWin;
                  if (hiWin == `DSPA_LOW_SLOT) begin
                    loLastQ <= loWin;
                  end
                  if (winIdx != ownerQ) begin
                    gntQ <= 7'h00;
                    nextOwnerQ <= winIdx;
                    stateQ <= `DSPA_ST_DEAD;
                  end
                end else if (parkLast || ownerQ == `DSPA_BRIDGE) begin
                  stateQ <= `DSPA_ST_PARK;
                end else begin
                  gntQ <= 7'h00;
                  nextOwnerQ <= `DSPA_BRIDGE;
                  stateQ <= `DSPA_ST_DEAD;
                end
              end
            end
            default: begin
              stateQ <= `DSPA_ST_PARK;
              gntQ <= 7'h00;
            end
          endcase
        end
      end

      ////////////////////////////////////////////////////////////////////
      // bridge drives the idle bus only while parked on itself; any request
      // drops the drive at the edge it is seen, which withdraws the bridge grant
      // unless the bridge itself wins, so the drive never outlives that grant
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          parkOeQ <= 1'b0;
        end else begin
          parkOeQ <= (stateQ == `DSPA_ST_PARK) && gntQ[`DSPA_BRIDGE] &&
                     busIdle && !hiAny;
        end
      end

      assign segGnt[7*s +: 7] = gntQ;
      assign segParkOe[s] = parkOeQ;
      // status: park drive, state, any grant, owner
      assign segStat[8*s +: 8] = {1'b0, parkOeQ, stateQ, |gntQ, ownerQ};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pin outputs; grants are flops, only the active-low flip is gating
  assign segAGnt_b = ~segGnt[5:0];
  assign segAIntGnt = segGnt[6];
  assign segBGnt_b = ~segGnt[12:7];
  assign segBIntGnt = segGnt[13];
  assign segAParkOe = segParkOe[0];
  assign segBParkOe = segParkOe[1];
  // fixed idle pattern; zero data with zero commands gives even parity
  assign segAParkAd = `DSPA_PARK_AD;
  assign segAParkCbe = `DSPA_PARK_CBE;
  assign segAParkPar = `DSPA_PARK_PAR;
  assign segBParkAd = `DSPA_PARK_AD;
  assign segBParkCbe = `DSPA_PARK_CBE;
  assign segBParkPar = `DSPA_PARK_PAR;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrValid = hsel & htrans[1] & hready;
  assign statWord = {16'h0000, segStat};

  // write data stands in the data phase; take it then
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPendQ <= 1'b0;
      wrAddrQ <= 8'h00;
    end else begin
      wrPendQ <= addrValid & hwrite;
      if (addrValid & hwrite) begin
        wrAddrQ <= haddr[7:0];
      end
    end
  end

  // control registers; a new value steers the next arbitration
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlAQ <= `DSPA_CTRL_RST;
      ctrlBQ <= `DSPA_CTRL_RST;
    end else if (wrPendQ) begin
      if (wrAddrQ == `DSPA_OFS_CTRL_A) begin
        ctrlAQ <= hwdata[15:0];
      end
      if (wrAddrQ == `DSPA_OFS_CTRL_B) begin
        ctrlBQ <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; forwards a write still in its data phase, so a read
  // right behind a write sees the new value
  always @* begin
    case (haddr[7:0])
      `DSPA_OFS_CTRL_A: begin
        rdData = (wrPendQ && wrAddrQ == `DSPA_OFS_CTRL_A) ?
                 {16'h0000, hwdata[15:0]} : {16'h0000, ctrlAQ};
      end
      `DSPA_OFS_CTRL_B: begin
        rdData = (wrPendQ && wrAddrQ == `DSPA_OFS_CTRL_B) ?
                 {16'h0000, hwdata[15:0]} : {16'h0000, ctrlBQ};
      end
      `DSPA_OFS_STATUS: begin
        rdData = statWord;
      end
      default: begin
        rdData = 32'h00000000; // unmapped reads as zero
      end
    endcase
  end

  // read data latched at the address phase, stands in the data phase
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (addrValid & !hwrite) begin
      hrdata <= rdData;
    end
  end

endmodule // dspa_arbiter

`default_nettype wire

// file: testbench/dspa_arbiter_asserts.sv
// port checker for the two-segment bus arbiter
// assumes: bound into dspa_arbiter, single core clock, reset active low
`timescale 1ns/1ps
`default_nettype none
module dspa_arbiter_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // segment grants and park drive
  input wire logic [5:0] segAReq_b,
  input wire logic [5:0] segAGnt_b,
  input wire logic segAIntGnt,
  input wire logic [5:0] segBGnt_b,
  input wire logic segBIntGnt,
  input wire logic segAParkOe,
  input wire logic [31:0] segAParkAd,
  input wire logic [3:0] segAParkCbe,
  input wire logic segAParkPar
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // all grants of segment a withdrawn
  sequence deadA;
    segAGnt_b == 6'h3f && !segAIntGnt;
  endsequence
  chk_one_grant_a: assert property ($onehot0({~segAGnt_b, segAIntGnt}))
    else $error("two grants on segment a");
  chk_one_grant_b: assert property ($onehot0({~segBGnt_b, segBIntGnt}))
    else $error("two grants on segment b");
  // a new owner only after a cycle with no grant, so drivers never overlap
  chk_gap_before: assert property ((~segAGnt_b & $past(segAGnt_b)) != 6'h0 |->
    $past(segAGnt_b) == 6'h3f && !$past(segAIntGnt))
    else $error("grant given without dead cycle");
  chk_dead_once: assert property (deadA |=> segAGnt_b != 6'h3f || segAIntGnt)
    else $error("dead cycle too long");
  // pin sampled four edges back: two sync flops, decision, dead cycle
  chk_grant_cause: assert property ($fell(segAGnt_b[0]) |-> $past(!segAReq_b[0], 4))
    else $error("grant without request");
  chk_park_drive: assert property (segAParkOe |-> segAIntGnt && segAParkAd == 32'h0 &&
    segAParkCbe == 4'h0 && !segAParkPar)
    else $error("park drive while not parked on bridge");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave response not ready okay");
  chk_unmapped_zero: assert property (hsel && htrans[1] && hready && !hwrite &&
    haddr == 32'hc |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // dspa_arbiter_chk
bind dspa_arbiter dspa_arbiter_chk i_dspa_arbiter_chk (.*);
`default_nettype wire

// file: testbench/dspa_pci_agents.sv
// six external masters of one segment, behavioural
// assumes: want from the bench, grants active low, frame and irdy high between transfers
`timescale 1ns/1ps
`default_nettype none
module dspa_pci_agents (
  // clock
  input wire logic clk,
  // bench wishes and arbiter grants
  input wire logic [5:0] want,
  input wire logic [5:0] gnt_b,
  // pins towards the arbiter
  output logic [5:0] req_b,
  output logic frame_b,
  output logic irdy_b
);
  int ph = 0;
  int gap = 0;
  initial begin
    req_b = 6'h3f;
    frame_b = 1'b1;
    irdy_b = 1'b1;
  end
  // start only when granted and idle; a gap lets the arbiter rotate
  always @(posedge clk) begin
    req_b <= ~want;
    if (ph == 1) begin
      frame_b <= 1'b1;
      ph <= 2;
    end else if (ph == 2) begin
      irdy_b <= 1'b1;
      ph <= 0;
      gap <= 8;
    end else if (gap > 0) begin
      gap <= gap - 1;
    end else if ((~gnt_b & want & ~req_b) != 6'h0 && frame_b && irdy_b) begin
      frame_b <= 1'b0;
      irdy_b <= 1'b0;
      ph <= 1;
    end
  end
endmodule // dspa_pci_agents
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the two-segment arbiter
// assumes: one slave on the register bus, agent models on both segments
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk, rst_b, hsel, hwrite, segAIntReq, segBIntReq;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] wantA, wantB;
  logic [5:0] prevA = 6'h3f;
  wire hready, hreadyout, hresp, segAFrame_b, segAIrdy_b, segBFrame_b, segBIrdy_b;
  wire segAIntGnt, segBIntGnt, segAParkOe, segBParkOe;
  wire [31:0] hrdata;
  wire [5:0] segAReq_b, segAGnt_b, segBReq_b, segBGnt_b;
  int errors = 0;
  int check_count = 0;
  int q[$];
  assign hready = hreadyout;
  dspa_arbiter i_dspa_arbiter (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .segAReq_b(segAReq_b), .segAGnt_b(segAGnt_b), .segAFrame_b(segAFrame_b),
    .segAIrdy_b(segAIrdy_b), .segAIntReq(segAIntReq), .segAIntGnt(segAIntGnt),
    .segAParkOe(segAParkOe), .segAParkAd(), .segAParkCbe(), .segAParkPar(),
    .segBReq_b(segBReq_b), .segBGnt_b(segBGnt_b), .segBFrame_b(segBFrame_b),
    .segBIrdy_b(segBIrdy_b), .segBIntReq(segBIntReq), .segBIntGnt(segBIntGnt),
    .segBParkOe(segBParkOe), .segBParkAd(), .segBParkCbe(), .segBParkPar());
  dspa_pci_agents i_agentsA (.clk(core_clk), .want(wantA), .gnt_b(segAGnt_b),
    .req_b(segAReq_b), .frame_b(segAFrame_b), .irdy_b(segAIrdy_b));
  dspa_pci_agents i_agentsB (.clk(core_clk), .want(wantB), .gnt_b(segBGnt_b),
    .req_b(segBReq_b), .frame_b(segBFrame_b), .irdy_b(segBIrdy_b));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // log each newly granted external master of segment a
  always @(posedge core_clk) begin
    for (int i = 0; i < 6; i++) if (prevA[i] && !segAGnt_b[i]) q.push_back(i);
    prevA <= segAGnt_b;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // masters in w compete until n grants are logged, then all let go
  task rec(input logic [5:0] w, input int n);
    q.delete();
    wantA <= w;
    for (int t = 0; t < 3000 && q.size() < n; t++) @(posedge core_clk);
    chk("grant count", q.size() >= n, 1);
    wantA <= 6'h0;
    repeat (40) @(posedge core_clk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
  initial begin
    {hsel, hwrite, segAIntReq, segBIntReq, rst_b} = 5'h0;
    {haddr, hwdata, htrans, wantA, wantB} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge core_clk);
    chk("reset park", {segAGnt_b, segAIntGnt}, 7'h7f);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("park drive", segAParkOe, 1);
    chk("park drive b", segBParkOe, 1);
    // both segments parked on the bridge, driving, owner index 6
    ahb(0, 32'h8, 0);
    chk("status", rd, 32'h00004e4e);
    ahb(0, 32'h0, 0);
    chk("ctrl a reset", rd, 32'h0);
    ahb(1, 32'h4, 32'hffff0155);
    ahb(0, 32'h4, 0);
    chk("ctrl b", rd, 32'h0155);
    ahb(0, 32'hc, 0);
    chk("unmapped", rd, 32'h0);
    ahb(1, 32'h4, 0);
    $display("register test done");
    rec(6'h07, 6);
    for (int i = 1; i < 6; i++) chk("high ring", q[i], (q[i-1] + 1) % 3);
    chk("idle to bridge", {segAGnt_b, segAIntGnt}, 7'h7f);
    ahb(1, 32'h0, 32'h6);
    rec(6'h07, 6);
    for (int i = 1; i < 6; i++) chk("low slot", q[i] == 0, q[i-1] != 0);
    for (int i = 2; i < 6; i++) if (q[i] != 0) chk("low ring", q[i], 3 - q[i-2]);
    ahb(1, 32'h0, 32'h7f);
    rec(6'h03, 4);
    for (int i = 1; i < 4; i++) chk("one group", q[i], 1 - q[i-1]);
    $display("rotation tests done");
    ahb(1, 32'h0, 32'h100);
    rec(6'h08, 1);
    chk("park last", {segAGnt_b, segAIntGnt}, 7'h6e);
    segAIntReq <= 1'b1;
    for (int t = 0; t < 500 && segAIntGnt !== 1'b1; t++) @(posedge core_clk);
    chk("internal grant", {segAGnt_b, segAIntGnt}, 7'h7f);
    segAIntReq <= 1'b0;
    wantB <= 6'h20;
    for (int t = 0; t < 500 && segBGnt_b[5] !== 1'b0; t++) @(posedge core_clk);
    chk("segment b grant", segBGnt_b, 6'h1f);
    chk("segment a alone", segAGnt_b, 6'h3f);
    $display("park and segment tests done");
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
